// ==== inc/sfc_pkg.sv ====
package sfc_pkg;

  localparam logic [7:0] OP_REGISTER_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_PROGRAM   = 8'h02;
  localparam logic [7:0] OP_READ           = 8'h03;
  localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;
  localparam logic [7:0] OP_READ_STATUS    = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
  localparam logic [7:0] OP_SMALL_ERASE    = 8'h20;
  localparam logic [7:0] OP_QUAD_PROGRAM   = 8'h32;
  localparam logic [7:0] OP_LARGE_ERASE    = 8'h40;
  localparam logic [7:0] OP_OTP_PROGRAM    = 8'h42;
  localparam logic [7:0] OP_RELEASE        = 8'hab;
  localparam logic [7:0] OP_DEEP_POWERDOWN = 8'hb9;
  localparam logic [7:0] OP_DUAL_IO_READ   = 8'hbb;
  localparam logic [7:0] OP_BULK_ERASE     = 8'hc7;
  localparam logic [7:0] OP_SECTOR_ERASE   = 8'hd8;
  localparam logic [7:0] OP_QUAD_IO_READ   = 8'heb;

  localparam int unsigned SR_BUSY    = 0;
  localparam int unsigned SR_WEL     = 1;
  localparam int unsigned SR_BP_LO   = 2;
  localparam int unsigned SR_BP_HI   = 4;
  localparam int unsigned SR_EERR    = 5;
  localparam int unsigned SR_PERR    = 6;
  localparam int unsigned SR_STATUS_WRITE_DISABLE    = 7;

  localparam logic [2:0] BP_RESET    = 3'h0;
  localparam logic       STATUS_WRITE_DISABLE_RESET  = 1'b0;

  localparam logic [2:0] LANES_1     = 3'h1;
  localparam logic [2:0] LANES_2     = 3'h2;
  localparam logic [2:0] LANES_4     = 3'h4;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [1:0] ADDR_LAST   = 2'h2;
  localparam logic [3:0] DUAL_GAP    = 4'h4;
  localparam logic [3:0] QUAD_GAP    = 4'h6;
  localparam int unsigned PAGE_DEPTH = 256;
  localparam logic [8:0] PAGE_BYTES  = 9'h100;
  localparam int unsigned ARR_AW     = 23;
  localparam int unsigned TIMER_W    = 24;

  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned PROG_TIME_NS   = 20000;
  localparam int unsigned REG_TIME_NS    = 8000;
  localparam int unsigned E4K_TIME_NS    = 40000;
  localparam int unsigned E8K_TIME_NS    = 60000;
  localparam int unsigned E64K_TIME_NS   = 80000;
  localparam int unsigned BULK_TIME_NS   = 160000;
  localparam int unsigned PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REG_CYCLES  = (REG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned E4K_CYCLES  = (E4K_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned E8K_CYCLES  = (E8K_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned E64K_CYCLES = (E64K_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BULK_CYCLES = (BULK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ARR_IDLE, ARR_READ, ARR_WRITE, ARR_ERASE} sfc_arr_op_e;
  typedef enum logic [1:0] {ER_4K, ER_8K, ER_64K, ER_ALL} sfc_erase_e;
  typedef enum {FE_CMD, FE_ADDR, FE_GAP, FE_RX, FE_TX, FE_DONE} sfc_fe_e;
  typedef enum {EX_IDLE, EX_PRD, EX_PWAIT, EX_PWR, EX_TIMED} sfc_ex_e;
  typedef enum {KIND_PROG, KIND_ERASE, KIND_REG} sfc_kind_e;

  typedef struct packed {
    sfc_arr_op_e       op;
    logic              otp;
    sfc_erase_e        size;
    logic [ARR_AW-1:0] addr;
    logic [7:0]        wdata;
  } sfc_arr_req_s;

endpackage

// ==== core/sfc_sync.sv ====
`timescale 1ns/1ps
module sfc_sync #(
  parameter int unsigned        WIDTH     = 1,
  parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta <= RESET_VAL;
      q_o  <= RESET_VAL;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

// ==== core/sfc_busy_timer.sv ====
`timescale 1ns/1ps
module sfc_busy_timer (
  input  wire logic                         clk_i,
  input  wire logic                         resetn_i,
  input  wire logic                         load_i,
  input  wire logic [sfc_pkg::TIMER_W-1:0]  count_i,
  output logic                              done_o
);

  logic [sfc_pkg::TIMER_W-1:0] cnt;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt    <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (load_i) begin
        cnt <= count_i;
      end else if (cnt != '0) begin
        cnt    <= cnt - 1'b1;
        done_o <= (cnt == 1);
      end
    end
  end

endmodule

// ==== core/sfc_flash_front.sv ====
`timescale 1ns/1ps
module sfc_flash_front #(
  parameter logic [23:0] PROG_CYCLES = 24'(sfc_pkg::PROG_CYCLES),
  parameter logic [23:0] REG_CYCLES  = 24'(sfc_pkg::REG_CYCLES),
  parameter logic [23:0] E4K_CYCLES  = 24'(sfc_pkg::E4K_CYCLES),
  parameter logic [23:0] E8K_CYCLES  = 24'(sfc_pkg::E8K_CYCLES),
  parameter logic [23:0] E64K_CYCLES = 24'(sfc_pkg::E64K_CYCLES),
  parameter logic [23:0] BULK_CYCLES = 24'(sfc_pkg::BULK_CYCLES)
) (
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  input  wire logic                 cs_n_i,
  input  wire logic                 sck_i,
  input  wire logic [3:0]           io_i,
  output logic      [3:0]           io_o,
  output logic      [3:0]           io_oe_o,
  output sfc_pkg::sfc_arr_req_s     arr_req_o,
  input  wire logic [7:0]           arr_rdata_i,
  input  wire logic                 arr_fail_i,
  output logic                      standby_o,
  output logic                      deep_powerdown_o,
  output logic      [7:0]           status_o
);

  logic [5:0]        sync_q;
  logic              s_cs_n;
  logic              s_sck;
  logic [3:0]        s_io;
  logic              sck_d;
  logic              cs_n_d;
  logic              hold_act;
  logic              sck_rise;
  logic              sck_fall;
  logic              cs_rise;

  sfc_pkg::sfc_fe_e  fe_state;
  logic [7:0]        cmd;
  logic [23:0]       addr;
  logic [7:0]        rx_sh;
  logic [3:0]        rx_bits;
  logic [2:0]        lanes;
  logic [1:0]        addr_idx;
  logic [3:0]        gap_cnt;
  logic [2:0]        pulse_cnt;
  logic [8:0]        data_cnt;
  logic [7:0]        wrr_data;
  logic [7:0]        next_sh;
  logic [3:0]        next_bits;
  logic              byte_done;

  logic [7:0]        page_buf [sfc_pkg::PAGE_DEPTH];
  logic              buf_we;
  logic [7:0]        buf_idx;

  logic [7:0]        tx_sh;
  logic [3:0]        tx_bits;
  logic [22:0]       rd_ofs;
  logic [22:0]       rd_addr;
  logic [7:0]        tx_cur;
  logic [3:0]        lane_mask;

  sfc_pkg::sfc_ex_e   ex_state;
  sfc_pkg::sfc_kind_e ex_kind;
  sfc_pkg::sfc_arr_req_s arr_req;
  logic              write_enable_latch;
  logic [2:0]        bp;
  logic              status_write_disable;
  logic              perr;
  logic              eerr;
  logic              dp;
  logic              busy;
  logic [7:0]        pidx;
  logic [8:0]        prem;
  logic              tmr_load;
  logic [23:0]       tmr_count;
  logic              tmr_done;
  logic [7:0]        status;
  logic              mod_ok;
  logic              hardware_protect_mode;
  logic              prot;
  logic              er_cmd;
  sfc_pkg::sfc_erase_e er_size;
  logic [23:0]       er_cycles;

  sfc_sync #(
    .WIDTH     (6),
    .RESET_VAL (6'h20)
  ) u_sync (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .d_i       ({cs_n_i, sck_i, io_i}),
    .q_o       (sync_q)
  );

  sfc_busy_timer u_timer (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .load_i    (tmr_load),
    .count_i   (tmr_count),
    .done_o    (tmr_done)
  );

  assign {s_cs_n, s_sck, s_io} = sync_q;

  // Edges found by level compare, so either idle clock level works
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sck_d  <= 1'b0;
      cs_n_d <= 1'b1;
    end else begin
      sck_d  <= s_sck;
      cs_n_d <= s_cs_n;
    end
  end

  // Hold pin doubles as data line 3 while four lanes are in use
  assign hold_act = ~s_cs_n & ~s_io[3] & (lanes != sfc_pkg::LANES_4);
  assign sck_rise = s_sck & ~sck_d & ~s_cs_n & ~hold_act;
  assign sck_fall = ~s_sck & sck_d & ~s_cs_n & ~hold_act;
  assign cs_rise  = s_cs_n & ~cs_n_d;

  function automatic logic takes_addr(input logic [7:0] op);
    takes_addr = (op == sfc_pkg::OP_READ) || (op == sfc_pkg::OP_PAGE_PROGRAM) ||
                 (op == sfc_pkg::OP_QUAD_PROGRAM) || (op == sfc_pkg::OP_OTP_PROGRAM) ||
                 (op == sfc_pkg::OP_SECTOR_ERASE) || (op == sfc_pkg::OP_SMALL_ERASE) ||
                 (op == sfc_pkg::OP_LARGE_ERASE) || (op == sfc_pkg::OP_DUAL_IO_READ) ||
                 (op == sfc_pkg::OP_QUAD_IO_READ);
  endfunction

  function automatic logic is_protected(input logic [6:0] sect, input logic [2:0] bpv);
    logic [7:0] span;
    span = 8'h01 << bpv;
    is_protected = (bpv != 3'h0) && ({1'b0, ~sect} < span);
  endfunction

  always_comb begin
    case (lanes)
      sfc_pkg::LANES_4: next_sh = {rx_sh[3:0], s_io};
      sfc_pkg::LANES_2: next_sh = {rx_sh[5:0], s_io[1:0]};
      default:          next_sh = {rx_sh[6:0], s_io[0]};
    endcase
    next_bits = rx_bits + {1'b0, lanes};
  end

  assign byte_done = (next_bits == sfc_pkg::BYTE_BITS);

  // Front end; no timeout, a stopped clock simply leaves state in place
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fe_state  <= sfc_pkg::FE_CMD;
      cmd       <= 8'h00;
      addr      <= 24'h000000;
      rx_sh     <= 8'h00;
      rx_bits   <= 4'h0;
      lanes     <= sfc_pkg::LANES_1;
      addr_idx  <= 2'h0;
      gap_cnt   <= 4'h0;
      pulse_cnt <= 3'h0;
      data_cnt  <= 9'h000;
      wrr_data  <= 8'h00;
    end else if (s_cs_n) begin
      fe_state  <= sfc_pkg::FE_CMD;
      rx_bits   <= 4'h0;
      lanes     <= sfc_pkg::LANES_1;
      addr_idx  <= 2'h0;
      pulse_cnt <= 3'h0;
    end else if (sck_rise) begin
      pulse_cnt <= pulse_cnt + 3'h1;
      rx_sh     <= next_sh;
      rx_bits   <= byte_done ? 4'h0 : next_bits;
      case (fe_state)
        sfc_pkg::FE_CMD: if (byte_done) begin
          cmd      <= next_sh;
          data_cnt <= 9'h000;
          if (takes_addr(next_sh)) begin
            fe_state <= sfc_pkg::FE_ADDR;
            if (next_sh == sfc_pkg::OP_DUAL_IO_READ) begin
              lanes <= sfc_pkg::LANES_2;
            end else if (next_sh == sfc_pkg::OP_QUAD_IO_READ) begin
              lanes <= sfc_pkg::LANES_4;
            end
          end else if (next_sh == sfc_pkg::OP_READ_STATUS) begin
            fe_state <= sfc_pkg::FE_TX;
          end else if (next_sh == sfc_pkg::OP_REGISTER_WRITE) begin
            fe_state <= sfc_pkg::FE_RX;
          end else begin
            fe_state <= sfc_pkg::FE_DONE;
          end
        end
        sfc_pkg::FE_ADDR: if (byte_done) begin
          addr     <= {addr[15:0], next_sh};
          addr_idx <= addr_idx + 2'h1;
          if (addr_idx == sfc_pkg::ADDR_LAST) begin
            case (cmd)
              sfc_pkg::OP_READ: fe_state <= sfc_pkg::FE_TX;
              sfc_pkg::OP_DUAL_IO_READ: begin
                fe_state <= sfc_pkg::FE_GAP;
                gap_cnt  <= sfc_pkg::DUAL_GAP;
              end
              sfc_pkg::OP_QUAD_IO_READ: begin
                fe_state <= sfc_pkg::FE_GAP;
                gap_cnt  <= sfc_pkg::QUAD_GAP;
              end
              sfc_pkg::OP_PAGE_PROGRAM, sfc_pkg::OP_OTP_PROGRAM: fe_state <= sfc_pkg::FE_RX;
              sfc_pkg::OP_QUAD_PROGRAM: begin
                fe_state <= sfc_pkg::FE_RX;
                lanes    <= sfc_pkg::LANES_4;
              end
              default: fe_state <= sfc_pkg::FE_DONE;
            endcase
          end
        end
        sfc_pkg::FE_GAP: begin
          rx_bits <= 4'h0;
          gap_cnt <= gap_cnt - 4'h1;
          if (gap_cnt == 4'h1) begin
            fe_state <= sfc_pkg::FE_TX;
          end
        end
        sfc_pkg::FE_RX: if (byte_done) begin
          if (data_cnt != sfc_pkg::PAGE_BYTES) begin
            data_cnt <= data_cnt + 9'h001;
          end
          if (cmd == sfc_pkg::OP_REGISTER_WRITE && data_cnt == 9'h000) begin
            wrr_data <= next_sh;
          end
        end
        default: ;
      endcase
    end
  end

  // Column wraps within the page, bytes past the 256th all land on the start column; buffer frozen while an operation runs
  assign buf_idx = addr[7:0] + data_cnt[7:0];
  assign buf_we  = sck_rise & byte_done & ~busy & (fe_state == sfc_pkg::FE_RX) &
                   (cmd != sfc_pkg::OP_REGISTER_WRITE);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < sfc_pkg::PAGE_DEPTH; i++) begin
        page_buf[i] <= 8'h00;
      end
    end else if (buf_we) begin
      page_buf[buf_idx] <= next_sh;
    end
  end

  assign status = {status_write_disable, perr, eerr, bp, write_enable_latch, busy};
  assign rd_addr = addr[22:0] + rd_ofs;
  assign tx_cur  = (tx_bits == 4'h0) ?
                   ((cmd == sfc_pkg::OP_READ_STATUS) ? status : arr_rdata_i) : tx_sh;

  always_comb begin
    case (lanes)
      sfc_pkg::LANES_4: lane_mask = 4'hf;
      sfc_pkg::LANES_2: lane_mask = 4'h3;
      default:          lane_mask = 4'h2;
    endcase
  end

  // Output shifter, new bits only after falling clock edges
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_sh   <= 8'h00;
      tx_bits <= 4'h0;
      rd_ofs  <= 23'h000000;
      io_o    <= 4'h0;
      io_oe_o <= 4'h0;
    end else begin
      io_oe_o <= (fe_state == sfc_pkg::FE_TX && !s_cs_n && !hold_act) ? lane_mask : 4'h0;
      if (s_cs_n) begin
        tx_bits <= 4'h0;
        rd_ofs  <= 23'h000000;
      end else if (sck_fall && fe_state == sfc_pkg::FE_TX) begin
        tx_bits <= (tx_bits == 4'h0) ? sfc_pkg::BYTE_BITS - {1'b0, lanes} - 4'h0 :
                   tx_bits - {1'b0, lanes};
        if (tx_bits == 4'h0 && cmd != sfc_pkg::OP_READ_STATUS) begin
          rd_ofs <= rd_ofs + 23'h000001;
        end
        case (lanes)
          sfc_pkg::LANES_4: begin
            io_o  <= tx_cur[7:4];
            tx_sh <= {tx_cur[3:0], 4'h0};
          end
          sfc_pkg::LANES_2: begin
            io_o  <= {2'b00, tx_cur[7:6]};
            tx_sh <= {tx_cur[5:0], 2'b00};
          end
          default: begin
            io_o  <= {2'b00, tx_cur[7], 1'b0};
            tx_sh <= {tx_cur[6:0], 1'b0};
          end
        endcase
      end
    end
  end

  assign busy   = (ex_state != sfc_pkg::EX_IDLE);
  assign mod_ok = (pulse_cnt == 3'h0) & write_enable_latch & ~busy & ~dp;
  assign hardware_protect_mode    = status_write_disable & ~s_io[2];
  assign prot   = is_protected(addr[22:16], bp);

  always_comb begin
    er_cmd    = 1'b1;
    er_size   = sfc_pkg::ER_64K;
    er_cycles = E64K_CYCLES;
    case (cmd)
      sfc_pkg::OP_SMALL_ERASE: begin
        er_size   = sfc_pkg::ER_4K;
        er_cycles = E4K_CYCLES;
      end
      sfc_pkg::OP_LARGE_ERASE: begin
        er_size   = sfc_pkg::ER_8K;
        er_cycles = E8K_CYCLES;
      end
      sfc_pkg::OP_SECTOR_ERASE: ;
      default: er_cmd = 1'b0;
    endcase
  end

  // Commands take effect when the frame ends
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ex_state  <= sfc_pkg::EX_IDLE;
      ex_kind   <= sfc_pkg::KIND_PROG;
      arr_req   <= '0;
      write_enable_latch       <= 1'b0;
      bp        <= sfc_pkg::BP_RESET;
      status_write_disable      <= sfc_pkg::STATUS_WRITE_DISABLE_RESET;
      perr      <= 1'b0;
      eerr      <= 1'b0;
      dp        <= 1'b0;
      pidx      <= 8'h00;
      prem      <= 9'h000;
      tmr_load  <= 1'b0;
      tmr_count <= 24'h000000;
    end else begin
      tmr_load <= 1'b0;
      case (ex_state)
        sfc_pkg::EX_IDLE: begin
          arr_req.op    <= (fe_state == sfc_pkg::FE_TX && cmd != sfc_pkg::OP_READ_STATUS) ?
                           sfc_pkg::ARR_READ : sfc_pkg::ARR_IDLE;
          arr_req.otp   <= 1'b0;
          arr_req.addr  <= rd_addr;
          arr_req.wdata <= 8'h00;
          if (cs_rise) begin
            if (cmd == sfc_pkg::OP_WRITE_ENABLE && fe_state == sfc_pkg::FE_DONE) begin
              write_enable_latch <= 1'b1;
            end else if (cmd == sfc_pkg::OP_WRITE_DISABLE && fe_state == sfc_pkg::FE_DONE) begin
              write_enable_latch <= 1'b0;
            end else if (cmd == sfc_pkg::OP_DEEP_POWERDOWN && fe_state == sfc_pkg::FE_DONE) begin
              dp <= 1'b1;
            end else if (cmd == sfc_pkg::OP_RELEASE && fe_state == sfc_pkg::FE_DONE) begin
              dp <= 1'b0;
            end else if ((cmd == sfc_pkg::OP_PAGE_PROGRAM || cmd == sfc_pkg::OP_QUAD_PROGRAM ||
                          cmd == sfc_pkg::OP_OTP_PROGRAM) && mod_ok &&
                         fe_state == sfc_pkg::FE_RX && data_cnt != 9'h000 &&
                         (cmd == sfc_pkg::OP_OTP_PROGRAM || !prot)) begin
              ex_state    <= sfc_pkg::EX_PRD;
              ex_kind     <= sfc_pkg::KIND_PROG;
              arr_req.otp <= (cmd == sfc_pkg::OP_OTP_PROGRAM);
              pidx        <= addr[7:0];
              prem        <= data_cnt;
            end else if (er_cmd && mod_ok && fe_state == sfc_pkg::FE_DONE && !prot) begin
              ex_state     <= sfc_pkg::EX_TIMED;
              ex_kind      <= sfc_pkg::KIND_ERASE;
              arr_req.op   <= sfc_pkg::ARR_ERASE;
              arr_req.size <= er_size;
              arr_req.addr <= addr[22:0];
              tmr_load     <= 1'b1;
              tmr_count    <= er_cycles;
            end else if (cmd == sfc_pkg::OP_BULK_ERASE && mod_ok &&
                         fe_state == sfc_pkg::FE_DONE && bp == 3'h0) begin
              ex_state     <= sfc_pkg::EX_TIMED;
              ex_kind      <= sfc_pkg::KIND_ERASE;
              arr_req.op   <= sfc_pkg::ARR_ERASE;
              arr_req.size <= sfc_pkg::ER_ALL;
              tmr_load     <= 1'b1;
              tmr_count    <= BULK_CYCLES;
            end else if (cmd == sfc_pkg::OP_REGISTER_WRITE && mod_ok &&
                         fe_state == sfc_pkg::FE_RX && data_cnt != 9'h000 && !hardware_protect_mode) begin
              ex_state  <= sfc_pkg::EX_TIMED;
              ex_kind   <= sfc_pkg::KIND_REG;
              bp        <= wrr_data[sfc_pkg::SR_BP_HI:sfc_pkg::SR_BP_LO];
              status_write_disable      <= wrr_data[sfc_pkg::SR_STATUS_WRITE_DISABLE];
              tmr_load  <= 1'b1;
              tmr_count <= REG_CYCLES;
            end
          end
        end
        sfc_pkg::EX_PRD: begin
          arr_req.op   <= sfc_pkg::ARR_READ;
          arr_req.addr <= {addr[22:8], pidx};
          ex_state     <= sfc_pkg::EX_PWAIT;
        end
        sfc_pkg::EX_PWAIT: ex_state <= sfc_pkg::EX_PWR;
        sfc_pkg::EX_PWR: begin
          arr_req.op    <= sfc_pkg::ARR_WRITE;
          arr_req.wdata <= arr_rdata_i & page_buf[pidx];
          pidx          <= pidx + 8'h01;
          prem          <= prem - 9'h001;
          if (prem == 9'h001) begin
            ex_state  <= sfc_pkg::EX_TIMED;
            tmr_load  <= 1'b1;
            tmr_count <= PROG_CYCLES;
          end else begin
            ex_state <= sfc_pkg::EX_PRD;
          end
        end
        default: begin
          arr_req.op <= sfc_pkg::ARR_IDLE;
          if (tmr_done) begin
            ex_state <= sfc_pkg::EX_IDLE;
            write_enable_latch      <= 1'b0;
            if (ex_kind == sfc_pkg::KIND_PROG) begin
              perr <= arr_fail_i;
            end else if (ex_kind == sfc_pkg::KIND_ERASE) begin
              eerr <= arr_fail_i;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      standby_o        <= 1'b1;
      deep_powerdown_o <= 1'b0;
      status_o         <= 8'h00;
    end else begin
      standby_o        <= s_cs_n & ~busy;
      deep_powerdown_o <= dp;
      status_o         <= status;
    end
  end

  assign arr_req_o = arr_req;

endmodule

// ==== tb/sfc_chk.sv ====
`timescale 1ns/1ps
module sfc_chk (
  input wire logic                  clk_i,
  input wire logic                  resetn_i,
  input wire logic                  cs_n_i,
  input wire logic [3:0]            io_oe_o,
  input wire sfc_pkg::sfc_arr_req_s arr_req_o,
  input wire logic                  standby_o,
  input wire logic                  deep_powerdown_o,
  input wire logic [7:0]            status_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Five cycles cover the pin synchronizers
  sequence s_sel; !cs_n_i [*5]; endsequence
  sequence s_off; cs_n_i [*5]; endsequence
  a_oe_lanes: assert property (io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("odd enable pattern");
  a_off_float: assert property (s_off |-> io_oe_o == 4'h0)
    else $error("drives while off");
  a_sel_active: assert property (s_sel |-> !standby_o)
    else $error("standby while on");
  a_wr_pulse: assert property (arr_req_o.op == sfc_pkg::ARR_WRITE
    |=> arr_req_o.op != sfc_pkg::ARR_WRITE) else $error("long write");
  a_erase_busy: assert property (arr_req_o.op == sfc_pkg::ARR_ERASE
    |-> ##[1:4] status_o[0]) else $error("erase not busy");
  a_busy_wel: assert property ($rose(status_o[0]) |-> status_o[1])
    else $error("busy without wel");
  a_wel_clear: assert property ($fell(status_o[0]) |-> ##[0:2] !status_o[1])
    else $error("wel kept");
  a_dpd_lock: assert property ($past(deep_powerdown_o) |->
    !(arr_req_o.op inside {sfc_pkg::ARR_WRITE, sfc_pkg::ARR_ERASE})) else $error("dpd write");
endmodule
bind sfc_flash_front sfc_chk u_chk (.clk_i, .resetn_i, .cs_n_i, .io_oe_o, .arr_req_o,
  .standby_o, .deep_powerdown_o, .status_o);

// ==== tb/sfc_arr_model.sv ====
`timescale 1ns/1ps
module sfc_arr_model (
  input  wire logic                  clk_i,
  input  wire sfc_pkg::sfc_arr_req_s req_i,
  output logic [7:0]                 rd_o,
  output logic [1:0]                 size_o
);
  // One page stands in for the array
  logic [7:0] mem [256];
  initial foreach (mem[i]) mem[i] = 8'hff;
  always @(posedge clk_i) begin
    // Core reads back two edges after it sets the address, so one stage only
    rd_o <= mem[req_i.addr[7:0]];
    if (req_i.op == sfc_pkg::ARR_WRITE) mem[req_i.addr[7:0]] <= req_i.wdata;
    if (req_i.op == sfc_pkg::ARR_ERASE) begin
      foreach (mem[i]) mem[i] <= 8'hff;
      size_o <= req_i.size;
    end
  end
endmodule

// ==== tb/spi_flash_command_status_tb.sv ====
`timescale 1ns/1ps
module spi_flash_command_status_tb;
  logic                  clk_i = 1'b0, resetn_i = 1'b0, cs_n_i = 1'b1, sck_i = 1'b0;
  logic                  arr_fail_i = 1'b0, m3 = 1'b0, standby_o, deep_powerdown_o;
  logic [3:0]            io_i = 4'hd, io_o, io_oe_o;
  logic [7:0]            rd, status_o;
  logic [15:0]           r;
  logic [1:0]            sz;
  sfc_pkg::sfc_arr_req_s arr_req_o;
  int                    bad_count = 0, tests_run = 0;
  always #2 clk_i = ~clk_i;
  sfc_flash_front #(.PROG_CYCLES(24'h14), .E4K_CYCLES(24'h14), .E8K_CYCLES(24'h14),
    .E64K_CYCLES(24'h14), .REG_CYCLES(24'h14)) dut (.clk_i, .resetn_i, .cs_n_i, .sck_i, .io_i, .io_o,
    .io_oe_o, .arr_req_o, .arr_rdata_i(rd), .arr_fail_i, .standby_o, .deep_powerdown_o,
    .status_o);
  sfc_arr_model u_arr (.clk_i, .req_i(arr_req_o), .rd_o(rd), .size_o(sz));
  task automatic ck(input logic c, input string m);
    tests_run++;
    if (c !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic bx(input logic b);
    sck_i = 1'b0;
    io_i[0] = b;
    wt(20);
    r = {r[14:0], io_o[1]};
    sck_i = 1'b1;
    wt(20);
  endtask
  // Optional extra bit breaks the byte count
  task automatic fr(input logic [7:0] q[$], input logic x = 1'b0);
    cs_n_i = 1'b0;
    wt(8);
    foreach (q[i]) for (int k = 7; k >= 0; k--) bx(q[i][k]);
    if (x) bx(1'b0);
    sck_i = m3;
    wt(8);
    cs_n_i = 1'b1;
    wt(8);
  endtask
  task automatic idle;
    for (int i = 0; i < 200 && status_o[0] !== 1'b0; i++) wt(1);
  endtask
  task automatic t_reset;
    ck(status_o === 8'h00 && standby_o === 1'b1, "reset state");
  endtask
  task automatic t_wel;
    fr({8'h02, 8'h00, 8'h00, 8'h10, 8'h00});
    ck(status_o[1:0] === 2'b00, "ran without wel");
    fr({8'h06});
    ck(status_o[1] === 1'b1, "wel not set");
    fr({8'h02, 8'h00, 8'h00, 8'h10, 8'h00}, 1'b1);
    ck(status_o[1:0] === 2'b10, "odd count ran");
  endtask
  task automatic t_prog;
    fr({8'h02, 8'h00, 8'h00, 8'h10, 8'h3c, 8'ha5});
    wt(8);
    ck(status_o[0] === 1'b1 && standby_o === 1'b0, "not busy");
    idle;
    ck(status_o[1:0] === 2'b00 && standby_o === 1'b1, "after program");
    fr({8'h06});
    fr({8'h02, 8'h00, 8'h00, 8'h10, 8'h0f});
    idle;
    fr({8'h03, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00});
    ck(r === 16'h0ca5, "read back");
  endtask
  task automatic t_erase;
    logic [7:0] op [3] = '{8'h20, 8'h40, 8'hd8};
    foreach (op[i]) begin
      fr({8'h06});
      arr_fail_i = i[0];
      fr({op[i], 8'h00, 8'h00, 8'h10});
      idle;
      ck(sz === 2'(i) && status_o[5] === i[0], "erase size or flag");
    end
    fr({8'h03, 8'h00, 8'h00, 8'h10, 8'h00});
    ck(r[7:0] === 8'hff, "not erased");
  endtask
  task automatic t_dpd;
    fr({8'hb9});
    fr({8'h06});
    fr({8'hc7});
    ck(deep_powerdown_o === 1'b1 && status_o[0] === 1'b0, "erase in dpd");
    fr({8'hab});
  endtask
  task automatic t_quad;
    logic [31:0] h = 32'h32000020, d = 32'h12345678;
    fr({8'h06});
    cs_n_i = 1'b0;
    wt(8);
    for (int k = 31; k >= 0; k--) bx(h[k]);
    // High nibble first, four lanes per clock
    for (int k = 7; k >= 0; k--) begin
      sck_i = 1'b0;
      io_i = d[4*k+:4];
      wt(20);
      sck_i = 1'b1;
      wt(20);
    end
    sck_i = m3;
    io_i = 4'hd;
    wt(8);
    cs_n_i = 1'b1;
    wt(8);
    idle;
    fr({8'h03, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00});
    ck(r === 16'h1234, "quad program");
  endtask
  task automatic t_prot;
    fr({8'h06});
    fr({8'h04});
    ck(status_o[1] === 1'b0, "wel not cleared");
    fr({8'h06});
    fr({8'h01, 8'h9c});
    idle;
    ck(status_o === 8'h9c, "register write");
    fr({8'h06});
    fr({8'hd8, 8'h00, 8'h00, 8'h10});
    ck(status_o[1:0] === 2'b10, "protected erase ran");
    io_i[2] = 1'b0;
    fr({8'h01, 8'h00});
    ck(status_o === 8'h9e, "locked register written");
    io_i[2] = 1'b1;
    fr({8'h01, 8'h00});
    idle;
    ck(status_o === 8'h00, "register not unlocked");
  endtask
  task automatic t_m3;
    m3 = 1'b1;
    sck_i = 1'b1;
    wt(8);
    fr({8'h06});
    fr({8'h05, 8'h00});
    ck(r[7:0] === 8'h02, "mode 3 status");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    wt(60000);
    bad_count++;
    results;
  end
  initial begin
    wt(20);
    resetn_i = 1'b1;
    wt(8);
    t_reset;
    t_wel;
    t_prog;
    t_erase;
    t_quad;
    t_prot;
    t_dpd;
    t_m3;
    results;
  end
endmodule
